// ===== rtl/slmc_pkg.sv
package slmc_pkg;

	// Clock and timing figures.
	localparam int CLK_NS          = 25;
	localparam int FAST_SETTLE_NS  = 2000;
	localparam int FAST_SETTLE_CYC = (FAST_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SLOW_SETTLE_US  = 150;
	localparam int SLOW_SETTLE_CYC = (SLOW_SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_SLOW_US    = 150;
	localparam int WAKE_SLOW_CYC   = (WAKE_SLOW_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_FAST_NS    = 5000;
	localparam int WAKE_FAST_CYC   = (WAKE_FAST_NS + CLK_NS - 1) / CLK_NS;
	localparam int RISK_WIN_NS     = 1000;
	localparam int RISK_WIN_CYC    = RISK_WIN_NS / CLK_NS;

	// Bus and counter widths.
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int CW = 16;

	// Register offsets.
	localparam logic [7:0] OFF_LOW_CTRL  = 8'h00;
	localparam logic [7:0] OFF_HIGH_CTRL = 8'h04;
	localparam logic [7:0] OFF_STATUS    = 8'h08;
	localparam logic [7:0] OFF_MASK      = 8'h0c;
	localparam logic [7:0] OFF_PWR_FLAG  = 8'h10;

	// Control register fields, same layout on both sides.
	localparam int CTL_W       = 6;
	localparam int B_SUP_EN    = 0;
	localparam int B_SUP_KEEP  = 1;
	localparam int B_SUP_FP    = 2;
	localparam int B_MON_EN    = 3;
	localparam int B_MON_FP    = 4;
	localparam int B_AUTO      = 5;
	localparam logic [5:0] CTRL_RST = 6'h00;

	// Status and mask fields.
	localparam int EV_W            = 5;
	localparam int EV_LOW_SETTLED  = 0;
	localparam int EV_HIGH_SETTLED = 1;
	localparam int EV_WAKE_DONE    = 2;
	localparam int EV_WAKE_LOST    = 3;
	localparam int EV_ENTRY_BLOCK  = 4;
	localparam logic [4:0] EV_RST  = 5'h00;

	// Power flag readback fields.
	localparam int PF_LOW_SETTLE  = 0;
	localparam int PF_HIGH_SETTLE = 1;
	localparam int PF_RISK        = 2;
	localparam int PF_SLOW        = 3;
	localparam int PF_FSM         = 4;
	localparam int PF_UNITS       = 6;

	typedef enum logic [1:0] {
		UNIT_OFF    = 2'b00,
		UNIT_NORMAL = 2'b01,
		UNIT_FULL   = 2'b10
	} slmc_unit_t;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_DEEP = 2'b01,
		ST_WAKE = 2'b10,
		ST_HUNG = 2'b11
	} slmc_state_t;

endpackage : slmc_pkg

// ===== rtl/slmc_top.sv
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - Low side wakes fast when its units are off or in full performance, slow when normal.
// - A low-side supervisor in normal performance stretches deep-mode wake-up to ~150 us.
// - In deep modes a low supervisor keeps state if manual and keep set, else auto-normal or off.
// - In deep modes a low monitor keeps state if manual, else full drops to normal, normal off.
// - The high supervisor follows the same state scheme as the low supervisor.
// - The high monitor follows the same state scheme as the low monitor.
// - Risk is 1 for fast low side with a non-full high supervisor, keep clear or auto.
// - Risk is 1 for fast low side with a non-full high monitor under high auto control.
// - Risk is 0 for every other combination of control bits.
// - In a risky setup a wake event within 1 us of deep entry hangs until reset.
module slmc_top
	import slmc_pkg::*;
#(
	parameter int SETTLE_SLOW_CYC = SLOW_SETTLE_CYC,
	parameter int WAKE_SLOW_CYCLES = WAKE_SLOW_CYC
) (
	input  wire logic          mclk,
	input  wire logic          arst_n,
	input  wire logic [AW-1:0] reg_addr,
	input  wire logic [DW-1:0] reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [DW-1:0] reg_rdata,
	input  wire logic          deep_req,
	input  wire logic          wake_evt,
	output logic               deep_active,
	output logic               waking,
	output logic               entry_ok,
	output logic               wake_slow,
	output logic               wake_risk,
	output logic               hung,
	output slmc_unit_t         low_sup_state,
	output slmc_unit_t         low_mon_state,
	output slmc_unit_t         high_sup_state,
	output slmc_unit_t         high_mon_state,
	output logic               irq
);

	logic [CTL_W-1:0] low_q;
	logic [CTL_W-1:0] high_q;
	logic [EV_W-1:0]  mask_q;
	logic [EV_W-1:0]  stat_q;
	logic [EV_W-1:0]  stat_d;
	logic [EV_W-1:0]  ev;
	logic [CW-1:0]    low_cnt_q;
	logic [CW-1:0]    high_cnt_q;
	logic [CW-1:0]    cnt_q;
	logic [CW-1:0]    cnt_d;
	logic [DW-1:0]    rdata_q;
	slmc_state_t      st_q;
	slmc_state_t      st_d;

	wire wr_low  = reg_wr && (reg_addr == OFF_LOW_CTRL);
	wire wr_high = reg_wr && (reg_addr == OFF_HIGH_CTRL);
	wire wr_stat = reg_wr && (reg_addr == OFF_STATUS);
	wire wr_mask = reg_wr && (reg_addr == OFF_MASK);

	wire lse   = low_q[B_SUP_EN];
	wire lfp   = low_q[B_SUP_FP];
	wire lme   = low_q[B_MON_EN];
	wire lmfp  = low_q[B_MON_FP];
	wire hse   = high_q[B_SUP_EN];
	wire hkeep = high_q[B_SUP_KEEP];
	wire hfp   = high_q[B_SUP_FP];
	wire hme   = high_q[B_MON_EN];
	wire hmfp  = high_q[B_MON_FP];
	wire hauto = high_q[B_AUTO];

	wire low_settling  = (low_cnt_q != '0);
	wire high_settling = (high_cnt_q != '0);

	// Low side counts as fast unless both units sit in normal performance.
	wire low_fast = !lse || (lse && lfp) || !lme || (lme && lmfp);
	wire sup_hit  = hse && !hfp && (!hkeep || (hkeep && hauto));
	wire mon_hit  = hme && !hmfp && hauto;
	assign wake_risk = low_fast && (sup_hit || mon_hit);

	// Either low unit in normal performance forces the slow wake-up.
	assign wake_slow = (lse && !lfp) || (lme && !lmfp);

	assign entry_ok    = !low_settling && !high_settling;
	assign deep_active = (st_q == ST_DEEP);
	assign waking      = (st_q == ST_WAKE);
	assign hung        = (st_q == ST_HUNG);

	// Unit state decoders.
	slmc_unit_if ls_if ();
	slmc_unit_if lm_if ();
	slmc_unit_if hs_if ();
	slmc_unit_if hm_if ();

	assign ls_if.enable    = lse;
	assign ls_if.full_perf = lfp;
	assign ls_if.lpm_keep  = low_q[B_SUP_KEEP];
	assign ls_if.auto_ctrl = low_q[B_AUTO];
	assign ls_if.deep      = deep_active;
	assign lm_if.enable    = lme;
	assign lm_if.full_perf = lmfp;
	assign lm_if.lpm_keep  = 1'b1;
	assign lm_if.auto_ctrl = low_q[B_AUTO];
	assign lm_if.deep      = deep_active;
	assign hs_if.enable    = hse;
	assign hs_if.full_perf = hfp;
	assign hs_if.lpm_keep  = hkeep;
	assign hs_if.auto_ctrl = hauto;
	assign hs_if.deep      = deep_active;
	assign hm_if.enable    = hme;
	assign hm_if.full_perf = hmfp;
	assign hm_if.lpm_keep  = 1'b1;
	assign hm_if.auto_ctrl = hauto;
	assign hm_if.deep      = deep_active;

	slmc_unit_state u_low_sup (.u(ls_if.dec));
	slmc_unit_state u_low_mon (.u(lm_if.dec));
	slmc_unit_state u_high_sup (.u(hs_if.dec));
	slmc_unit_state u_high_mon (.u(hm_if.dec));

	assign low_sup_state  = ls_if.state;
	assign low_mon_state  = lm_if.state;
	assign high_sup_state = hs_if.state;
	assign high_mon_state = hm_if.state;

	// Control registers.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			low_q  <= CTRL_RST;
			high_q <= CTRL_RST;
			mask_q <= EV_RST;
		end else begin
			if (wr_low)
				low_q <= reg_wdata[CTL_W-1:0];
			if (wr_high)
				high_q <= reg_wdata[CTL_W-1:0];
			if (wr_mask)
				mask_q <= reg_wdata[EV_W-1:0];
		end
	end

	// Settle delay follows each control write; a supervisor full performance bit settles fast.
	wire [CW-1:0] low_load  = reg_wdata[B_SUP_FP] ? CW'(FAST_SETTLE_CYC) : CW'(SETTLE_SLOW_CYC);
	wire [CW-1:0] high_load = reg_wdata[B_SUP_FP] ? CW'(FAST_SETTLE_CYC) : CW'(SETTLE_SLOW_CYC);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			low_cnt_q  <= '0;
			high_cnt_q <= '0;
		end else begin
			if (wr_low)
				low_cnt_q <= low_load;
			else if (low_settling)
				low_cnt_q <= low_cnt_q - CW'(1);
			if (wr_high)
				high_cnt_q <= high_load;
			else if (high_settling)
				high_cnt_q <= high_cnt_q - CW'(1);
		end
	end

	// Power state sequencer.
	always_comb begin
		st_d  = st_q;
		cnt_d = (cnt_q != '0) ? cnt_q - CW'(1) : cnt_q;
		unique case (st_q)
			ST_RUN: begin
				if (deep_req && entry_ok) begin
					st_d  = ST_DEEP;
					cnt_d = CW'(RISK_WIN_CYC);
				end
			end
			ST_DEEP: begin
				if (wake_evt && wake_risk && (cnt_q != '0)) begin
					st_d = ST_HUNG;
				end else if (wake_evt) begin
					st_d  = ST_WAKE;
					cnt_d = wake_slow ? CW'(WAKE_SLOW_CYCLES) : CW'(WAKE_FAST_CYC);
				end
			end
			ST_WAKE: begin
				if (cnt_q == CW'(1))
					st_d = ST_RUN;
			end
			ST_HUNG: begin
				st_d = ST_HUNG;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q  <= ST_RUN;
			cnt_q <= '0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
		end
	end

	// Events, sticky status and interrupt; a new event beats a same-cycle clear.
	assign ev[EV_LOW_SETTLED]  = (low_cnt_q == CW'(1)) && !wr_low;
	assign ev[EV_HIGH_SETTLED] = (high_cnt_q == CW'(1)) && !wr_high;
	assign ev[EV_WAKE_DONE]    = (st_q == ST_WAKE) && (st_d == ST_RUN);
	assign ev[EV_WAKE_LOST]    = (st_q == ST_DEEP) && (st_d == ST_HUNG);
	assign ev[EV_ENTRY_BLOCK]  = (st_q == ST_RUN) && deep_req && !entry_ok;
	assign stat_d = (stat_q & ~(wr_stat ? reg_wdata[EV_W-1:0] : EV_RST)) | ev;
	assign irq    = |(stat_q & mask_q);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			stat_q <= EV_RST;
		else
			stat_q <= stat_d;
	end

	// Read path; data stands only in the cycle after the strobe.
	wire [DW-1:0] pf_word = {{(DW-14){1'b0}}, high_mon_state, high_sup_state,
		low_mon_state, low_sup_state, st_q, wake_slow, wake_risk,
		high_settling, low_settling};
	wire [DW-1:0] rd_mux =
		(reg_addr == OFF_LOW_CTRL)  ? {{(DW-CTL_W){1'b0}}, low_q}  :
		(reg_addr == OFF_HIGH_CTRL) ? {{(DW-CTL_W){1'b0}}, high_q} :
		(reg_addr == OFF_STATUS)    ? {{(DW-EV_W){1'b0}}, stat_q}  :
		(reg_addr == OFF_MASK)      ? {{(DW-EV_W){1'b0}}, mask_q}  :
		(reg_addr == OFF_PWR_FLAG)  ? pf_word : '0;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			rdata_q <= '0;
		else
			rdata_q <= reg_rd ? rd_mux : '0;
	end
	assign reg_rdata = rdata_q;

	// Checks.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	slow_wake_a:
	assert property (!deep_active |-> wake_slow ==
		((low_sup_state == UNIT_NORMAL) || (low_mon_state == UNIT_NORMAL)))
	else $error("wake speed does not follow low side setup");

	slow_load_a:
	assert property ((st_q == ST_DEEP) && wake_evt && !wake_risk && wake_slow
		|=> waking && (cnt_q == CW'(WAKE_SLOW_CYCLES)))
	else $error("slow wake time not loaded");

	entry_gate_a:
	assert property ((st_q == ST_RUN) && (low_settling || high_settling) |=> !deep_active)
	else $error("deep entry while settling");

	low_sup_lpm_a:
	assert property (deep_active && lse && !low_q[B_AUTO]
		|-> low_sup_state == (low_q[B_SUP_KEEP] ? (lfp ? UNIT_FULL : UNIT_NORMAL) : UNIT_OFF))
	else $error("low supervisor deep state wrong");

	low_mon_auto_a:
	assert property (deep_active && lme && low_q[B_AUTO]
		|-> low_mon_state == (lmfp ? UNIT_NORMAL : UNIT_OFF))
	else $error("low monitor auto deep state wrong");

	high_sup_act_a:
	assert property (!deep_active && hse |-> high_sup_state == (hfp ? UNIT_FULL : UNIT_NORMAL))
	else $error("high supervisor active state wrong");

	high_mon_keep_a:
	assert property (deep_active && $stable(high_q) && hme && !hauto
		|-> high_mon_state == $past(high_mon_state) || !$past(deep_active))
	else $error("high monitor left its state in manual deep mode");

	risk_set_a:
	assert property (low_fast && sup_hit |-> wake_risk)
	else $error("supervisor risk not reported");

	risk_mon_a:
	assert property (low_fast && hme && !hmfp && hauto |-> wake_risk)
	else $error("monitor risk not reported");

	risk_clear_a:
	assert property (!(low_fast && (sup_hit || mon_hit)) |-> !wake_risk)
	else $error("risk reported for safe setup");

	hang_hold_a:
	assert property (deep_active && wake_evt && wake_risk && (cnt_q != '0) |=> hung [*4])
	else $error("risky early wake did not hang");

	risk_track_a:
	assert property ($changed(wake_risk) |-> $changed(low_q) || $changed(high_q))
	else $error("risk changed without a control change");

endmodule : slmc_top

// ===== rtl/slmc_unit_if.sv
`timescale 1ns/1ps
interface slmc_unit_if;
	import slmc_pkg::*;
	logic       enable;
	logic       full_perf;
	logic       lpm_keep;
	logic       auto_ctrl;
	logic       deep;
	slmc_unit_t state;
	modport dec (input enable, input full_perf, input lpm_keep, input auto_ctrl,
		input deep, output state);
	modport ctl (output enable, output full_perf, output lpm_keep, output auto_ctrl,
		output deep, input state);
endinterface : slmc_unit_if

// ===== rtl/slmc_unit_state.sv
`timescale 1ns/1ps
module slmc_unit_state
	import slmc_pkg::*;
(
	slmc_unit_if.dec u
);
	slmc_unit_t act_state;
	slmc_unit_t lpm_manual;
	slmc_unit_t lpm_auto;

	// A monitor is a supervisor whose keep bit is tied high.
	assign act_state  = u.full_perf ? UNIT_FULL : UNIT_NORMAL;
	assign lpm_manual = u.lpm_keep ? act_state : UNIT_OFF;
	assign lpm_auto   = (u.lpm_keep && u.full_perf) ? UNIT_NORMAL : UNIT_OFF;
	assign u.state    = !u.enable ? UNIT_OFF :
		!u.deep ? act_state :
		u.auto_ctrl ? lpm_auto : lpm_manual;

endmodule : slmc_unit_state

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import slmc_pkg::*;
	localparam int SSLOW = 50;
	localparam int WSLOW = 60;
	logic          mclk        = 1'b0;
	logic          arst_n      = 1'b0;
	logic [AW-1:0] reg_addr    = '0;
	logic [DW-1:0] reg_wdata   = '0;
	logic          reg_wr      = 1'b0;
	logic          reg_rd      = 1'b0;
	logic          deep_req    = 1'b0;
	logic          wake_evt    = 1'b0;
	logic [DW-1:0] reg_rdata;
	logic          deep_active;
	logic          waking;
	logic          entry_ok;
	logic          wake_slow;
	logic          wake_risk;
	logic          hung;
	logic          irq;
	slmc_unit_t    ls_st;
	slmc_unit_t    lm_st;
	slmc_unit_t    hs_st;
	slmc_unit_t    hm_st;
	int            err_total   = 0;
	int            compares    = 0;
	logic [DW-1:0] rdv;

	slmc_top #(.SETTLE_SLOW_CYC(SSLOW), .WAKE_SLOW_CYCLES(WSLOW)) dut (
		.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .deep_req(deep_req),
		.wake_evt(wake_evt), .deep_active(deep_active), .waking(waking),
		.entry_ok(entry_ok), .wake_slow(wake_slow), .wake_risk(wake_risk), .hung(hung),
		.low_sup_state(ls_st), .low_mon_state(lm_st), .high_sup_state(hs_st),
		.high_mon_state(hm_st), .irq(irq));

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	task automatic print_verdict;
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : chk

	function automatic logic [1:0] exp_unit(input logic en, input logic keep, input logic fp,
		input logic auto, input logic deep);
		if (!en)
			return UNIT_OFF;
		if (!deep || (!auto && keep))
			return fp ? UNIT_FULL : UNIT_NORMAL;
		return (auto && keep && fp) ? UNIT_NORMAL : UNIT_OFF;
	endfunction : exp_unit

	function automatic logic exp_risk(input logic [5:0] l, input logic [5:0] h);
		logic fast;
		fast = !l[0] || l[2] || !l[3] || l[4];
		return fast && ((h[0] && !h[2] && (!h[1] || h[5])) || (h[3] && !h[4] && h[5]));
	endfunction : exp_risk

	function automatic logic exp_slow(input logic [5:0] l);
		return (l[0] && !l[2]) || (l[3] && !l[4]);
	endfunction : exp_slow

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic settle;
		int n;
		n = 0;
		while (entry_ok !== 1'b1 && n < 300) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(entry_ok, 1, "settle flags never cleared");
	endtask : settle

	task automatic enter_deep;
		@(posedge mclk);
		deep_req <= 1'b1;
		@(posedge mclk);
		deep_req <= 1'b0;
		#1;
	endtask : enter_deep

	task automatic pulse_wake;
		@(posedge mclk);
		wake_evt <= 1'b1;
		@(posedge mclk);
		wake_evt <= 1'b0;
		#1;
	endtask : pulse_wake

	task automatic t_reset;
		chk({irq, entry_ok, wake_risk, wake_slow}, 32'h4, "reset outputs");
		rd(OFF_PWR_FLAG, rdv);
		chk(rdv, 0, "reset power flags");
		rd(8'h14, rdv);
		chk(rdv, 0, "unmapped read");
	endtask : t_reset

	task automatic t_risk;
		for (int h = 0; h < 64; h++) begin
			wr(OFF_HIGH_CTRL, h);
			for (int l = 0; l < 64; l++) begin
				wr(OFF_LOW_CTRL, l);
				chk(wake_risk, exp_risk(6'(l), 6'(h)), "risk detector");
				chk(wake_slow, exp_slow(6'(l)), "wake speed");
			end
		end
	endtask : t_risk

	task automatic t_block;
		wr(OFF_STATUS, 32'h1f);
		wr(OFF_MASK, 32'h10);
		wr(OFF_LOW_CTRL, 32'h01);
		chk(entry_ok, 0, "entry allowed while settling");
		enter_deep();
		chk({deep_active, irq}, 32'h1, "blocked entry");
		wr(OFF_STATUS, 32'h10);
		chk(irq, 0, "irq after clear");
		settle();
	endtask : t_block

	task automatic t_deep;
		logic [5:0] v;
		int n;
		wr(OFF_MASK, 32'h04);
		for (int i = 0; i < 64; i++) begin
			v = 6'(i);
			wr(OFF_LOW_CTRL, v);
			wr(OFF_HIGH_CTRL, v);
			settle();
			chk(ls_st, exp_unit(v[0], v[1], v[2], v[5], 0), "low sup run");
			chk(hm_st, exp_unit(v[3], 1, v[4], v[5], 0), "high mon run");
			enter_deep();
			chk(deep_active, 1, "deep entry");
			chk(ls_st, exp_unit(v[0], v[1], v[2], v[5], 1), "low sup deep");
			chk(lm_st, exp_unit(v[3], 1, v[4], v[5], 1), "low mon deep");
			chk(hs_st, exp_unit(v[0], v[1], v[2], v[5], 1), "high sup deep");
			chk(hm_st, exp_unit(v[3], 1, v[4], v[5], 1), "high mon deep");
			repeat (45) @(posedge mclk);
			pulse_wake();
			n = 0;
			while (waking === 1'b1 && n < 500) begin
				n++;
				@(posedge mclk);
				#1;
			end
			chk(n, exp_slow(v) ? WSLOW : WAKE_FAST_CYC, "wake length");
			chk({hung, deep_active, irq}, 32'h1, "wake done");
			wr(OFF_STATUS, 32'h1f);
			chk(irq, 0, "irq cleared");
		end
	endtask : t_deep

	task automatic t_hang;
		wr(OFF_LOW_CTRL, 32'h00);
		wr(OFF_HIGH_CTRL, 32'h01);
		settle();
		chk(wake_risk, 1, "risky config");
		enter_deep();
		pulse_wake();
		repeat (20) @(posedge mclk);
		#1;
		chk({hung, waking, deep_active}, 32'h4, "hung after early wake");
		rd(OFF_PWR_FLAG, rdv);
		chk(rdv[5:2], 4'hd, "hung flags");
		rd(OFF_STATUS, rdv);
		chk(rdv, 32'h0b, "settled and wake lost events");
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		#1;
		chk({hung, wake_risk}, 0, "reset recovers");
		rd(OFF_HIGH_CTRL, rdv);
		chk(rdv, 0, "ctrl after reset");
	endtask : t_hang

	// High units kept on under manual control: an early wake is served, not lost.
	task automatic t_manual;
		wr(OFF_HIGH_CTRL, 32'h0b);
		settle();
		chk(wake_risk, 0, "manual high units safe");
		enter_deep();
		chk({hs_st, hm_st}, 32'h5, "high units kept on");
		pulse_wake();
		chk({hung, waking}, 32'h1, "early wake served");
		repeat (WAKE_FAST_CYC) @(posedge mclk);
		#1;
		chk({waking, deep_active, hung}, 0, "back to run");
	endtask : t_manual

	initial begin
		repeat (80000) @(posedge mclk);
		err_total++;
		$display("BAD %0t timeout", $time);
		print_verdict();
	end

	initial begin
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		#1;
		t_reset();
		t_risk();
		t_block();
		t_deep();
		t_hang();
		t_manual();
		print_verdict();
	end
endmodule : testbench
